/* File: ods_pkg.sv */
// ====================================================================
// shared constants and types for the octal converter frame decoder
// ====================================================================
package ods_pkg;

  // ==================================================================
  // serial word geometry
  // ==================================================================
  localparam int          WORD_W        = 32;
  localparam int          CNT_W         = 6;
  localparam logic [5:0]  LAST_BIT_IDX  = 6'h1F;  // index of 32nd bit
  localparam int          CODE_W        = 16;
  localparam int          CHANNELS      = 8;
  localparam logic [4:0]  RES_DEFAULT   = 5'h10;  // 16-bit variant

  // field layout of one received word, msb first
  typedef struct packed {
    logic [3:0]  prefix;
    logic [3:0]  command_field;
    logic [3:0]  channel_address_field;
    logic [15:0] conversion_code;
    logic [3:0]  feature_field;
  } ods_word_t;

  // ==================================================================
  // command and address codes
  // ==================================================================
  localparam logic [3:0]  CMD_WRITE_INPUT = 4'h0;
  localparam logic [3:0]  CMD_UPDATE_DAC  = 4'h1;
  localparam logic [3:0]  CMD_REF_DEFAULT = 4'h8;
  localparam logic [3:0]  ADDR_BROADCAST  = 4'hF;
  localparam int          REF_EN_BIT      = 0;    // feature bit

  // ==================================================================
  // register map (byte offsets) and fields
  // ==================================================================
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_LAST_WORD   = 8'h08;
  localparam logic [7:0]  OFS_FEATURE     = 8'h0C;
  localparam logic [7:0]  OFS_COUNTS      = 8'h10;
  localparam logic [2:0]  PAGE_INPUT      = 3'h1;  // 0x20..0x3C
  localparam logic [2:0]  PAGE_DAC        = 3'h2;  // 0x40..0x5C
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          STAT_REF_BIT    = 0;
  localparam int          STAT_LOCK_BIT   = 1;
  localparam int          STAT_FRAME_BIT  = 2;
  localparam int          STAT_RSV_BIT    = 3;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0001;
  localparam logic [15:0] CODE_RST        = 16'h0000;

  // ==================================================================
  // frame receiver states, gray along idle -> shift -> locked
  // ==================================================================
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_LOCKED = 2'b11
  } ods_state_t;

  // left-aligned code mask for a given resolution
  function automatic logic [15:0] code_mask(input logic [4:0] res);
    logic [15:0] m;
    m = 16'hFFFF << (5'h10 - res);
    return m;
  endfunction : code_mask

endpackage : ods_pkg

/* File: ods_pin_sync.sv */
`timescale 1ns/1ps
// ====================================================================
// two-stage pin synchroniser with edge detection
// ====================================================================
module ods_pin_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_async,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // idle-high reset: frame select and clock rest high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
      last_reg <= '1;
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;   // only reader of meta_reg
      last_reg <= sync_reg;
    end
  end

  // edges seen from the settled stages only
  assign level = sync_reg;
  assign fall  = last_reg & ~sync_reg;
  assign rise  = ~last_reg & sync_reg;

endmodule : ods_pin_sync

/* File: ods_frame_decoder.sv */
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// [RQ1] 32-bit word: prefix, command, address, code, feature
// [RQ2] host sends msb first, first bit zero
// [RQ3] ignore prefix, bits 27..24 are command
// [RQ4] bits 23..20 select one of eight channels
// [RQ5] code left-aligned, msb at bit 19
// [RQ6] bits below the code are ignored
// [RQ7] codes are straight binary, all ones full scale
// [RQ8] host lowers frame select before clocking
// [RQ9] data sampled on each serial clock fall
// [RQ10] lock after 32nd fall, further clocks ignored
// [RQ11] execute right after 32nd fall
// [RQ12] new word only at next frame-select fall
// [RQ13] early frame-select rise aborts, no command
// [RQ14] host waits minimum time before next frame
// [RQ15] reference disabled after reset until commanded
// [RQ16] command 0 loads channel input register
// [RQ17] address F broadcasts, other high addresses none; command 1 with address F updates no channel
// [RQ18] command 1 updates channel output register
// [RQ19] host never sends word with first bit one
// [RQ20] frame select high: clocks ignored, counter held
// [RQ21] feature bits kept for the command decoder
module ods_frame_decoder #(
  parameter int         RES_BITS = 16,
  parameter logic [3:0] CMD_REF  = ods_pkg::CMD_REF_DEFAULT
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        SYNC_N,
  input  wire logic        SCLK,
  input  wire logic        SDIN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             REF_EN,
  output logic             DAC_UPDATE
);

  localparam logic [4:0]  RES  = 5'(RES_BITS);
  localparam logic [15:0] MASK = ods_pkg::code_mask(RES);

  // ==================================================================
  // pin synchronisation
  // ==================================================================
  logic [2:0] pin_lvl;
  logic [2:0] pin_fall;
  logic [2:0] pin_rise;

  ods_pin_sync #(.W(3)) u_sync (
    .clk       (CLK),
    .rst_n     (RST_N),
    .pin_async ({SDIN, SCLK, SYNC_N}),
    .level     (pin_lvl),
    .fall      (pin_fall),
    .rise      (pin_rise)
  );

  // ==================================================================
  // receiver state
  // ==================================================================
  ods_pkg::ods_state_t  state_reg;
  logic [5:0]           bit_cnt_reg;
  logic [31:0]          sr_reg;
  logic [31:0]          ctrl_reg;
  logic                 frame_start;
  logic                 frame_end;
  logic                 sclk_take;
  logic                 word_done;
  logic                 word_ok;
  ods_pkg::ods_word_t   w_in;

  // a disabled receiver never opens a frame
  assign frame_start = pin_fall[0] & ctrl_reg[ods_pkg::CTRL_EN_BIT];
  assign frame_end   = pin_rise[0];
  // only falls inside an open, unlocked frame shift data
  assign sclk_take   = pin_fall[1] & ~pin_lvl[0] & ~frame_end &
                       (state_reg == ods_pkg::ST_SHIFT | frame_start);
  assign word_done   = sclk_take & ~frame_start &
                       (bit_cnt_reg == ods_pkg::LAST_BIT_IDX);   // [RQ11]
  // the word as it stands once the 32nd bit is in
  assign w_in        = ods_pkg::ods_word_t'({sr_reg[30:0], pin_lvl[2]});
  // a word with its first bit set is reserved and not executed
  assign word_ok     = word_done & ~w_in.prefix[3];

  // frame state machine
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ods_pkg::ST_IDLE;
    end else if (frame_start) begin
      state_reg <= ods_pkg::ST_SHIFT;                    // [RQ12]
    end else if (frame_end) begin
      state_reg <= ods_pkg::ST_IDLE;                     // [RQ13]
    end else begin
      unique case (state_reg)
        ods_pkg::ST_IDLE:   state_reg <= ods_pkg::ST_IDLE;     // [RQ20]
        ods_pkg::ST_SHIFT: begin
          if (word_done) begin
            state_reg <= ods_pkg::ST_LOCKED;             // [RQ10]
          end
        end
        ods_pkg::ST_LOCKED: state_reg <= ods_pkg::ST_LOCKED;
        default:            state_reg <= ods_pkg::ST_IDLE;
      endcase
    end
  end

  // bit counter, restarted by each frame-select fall that opens a frame
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_cnt_reg <= '0;
    end else if (frame_start) begin
      bit_cnt_reg <= sclk_take ? 6'h01 : 6'h00;
    end else if (frame_end) begin
      bit_cnt_reg <= '0;                                 // [RQ13]
    end else if (sclk_take) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;                // [RQ9]
    end
  end

  // shift register, msb enters first; frozen once locked
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sr_reg <= '0;
    end else if (sclk_take) begin
      sr_reg <= {sr_reg[30:0], pin_lvl[2]};              // [RQ9] [RQ1]
    end
  end

  // ==================================================================
  // command execution
  // ==================================================================
  logic [7:0][15:0] input_reg;
  logic [7:0][15:0] dac_reg;
  logic             ref_en_reg;
  logic [3:0]       feature_reg;
  logic [31:0]      last_word_reg;
  logic             dac_update_reg;
  logic [2:0]       ch;
  logic [15:0]      code;

  assign ch   = w_in.channel_address_field[2:0];         // [RQ4]
  // low bits under the code are forced to zero
  assign code = w_in.conversion_code & MASK;             // [RQ5] [RQ6]

  // channel input registers, written by command 0
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      input_reg <= '0;
    end else if (word_ok &&
                 w_in.command_field == ods_pkg::CMD_WRITE_INPUT) begin // [RQ3]
      if (w_in.channel_address_field == ods_pkg::ADDR_BROADCAST) begin
        input_reg <= {8{code}};                          // [RQ17]
      end else if (!w_in.channel_address_field[3]) begin
        input_reg[ch] <= code;                           // [RQ16] [RQ7]
      end
    end
  end

  // output registers, copied from input by command 1
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dac_reg        <= '0;
      dac_update_reg <= 1'b0;
    end else begin
      dac_update_reg <= 1'b0;
      if (word_ok && w_in.command_field == ods_pkg::CMD_UPDATE_DAC &&
          !w_in.channel_address_field[3]) begin
        dac_reg[ch]    <= input_reg[ch];                 // [RQ18]
        dac_update_reg <= 1'b1;
      end
    end
  end

  // reference stays off until a reference command turns it on
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_en_reg <= 1'b0;                                // [RQ15]
    end else if (word_ok && w_in.command_field == CMD_REF) begin
      ref_en_reg <= w_in.feature_field[ods_pkg::REF_EN_BIT];
    end
  end

  // last word and feature bits kept for software and decoder
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      last_word_reg <= '0;
      feature_reg   <= '0;
    end else if (word_done) begin
      last_word_reg <= w_in;
      feature_reg   <= w_in.feature_field;               // [RQ21]
    end
  end

  // ==================================================================
  // statistics and reserved-word flag
  // ==================================================================
  logic [15:0] done_cnt_reg;
  logic [15:0] abort_cnt_reg;
  logic        rsv_reg;
  logic        apb_done;
  logic        apb_wr;

  // counters wrap; they are for software diagnostics only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_cnt_reg  <= '0;
      abort_cnt_reg <= '0;
    end else begin
      if (word_done) begin
        done_cnt_reg <= done_cnt_reg + 16'h0001;
      end
      if (frame_end && state_reg == ods_pkg::ST_SHIFT && !frame_start) begin
        abort_cnt_reg <= abort_cnt_reg + 16'h0001;       // [RQ13]
      end
    end
  end

  // sticky flag; a new reserved word beats a clear in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsv_reg <= 1'b0;
    end else if (word_done && w_in.prefix[3]) begin
      rsv_reg <= 1'b1;                                   // [RQ19]
    end else if (apb_wr && PADDR == ods_pkg::OFS_STATUS &&
                 PWDATA[ods_pkg::STAT_RSV_BIT]) begin
      rsv_reg <= 1'b0;
    end
  end

  // ==================================================================
  // apb slave: one wait state, answer on the second access cycle
  // ==================================================================
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign apb_done = PSEL & PENABLE & pready_reg;
  assign apb_wr   = apb_done & PWRITE;

  // read decode
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (PADDR[7:5] == ods_pkg::PAGE_INPUT && PADDR[1:0] == 2'b00) begin
      rd_val = {16'h0000, input_reg[PADDR[4:2]]};
    end else if (PADDR[7:5] == ods_pkg::PAGE_DAC &&
                 PADDR[1:0] == 2'b00) begin
      rd_val = {16'h0000, dac_reg[PADDR[4:2]]};
    end else begin
      unique case (PADDR)
        ods_pkg::OFS_CTRL:      rd_val = ctrl_reg;
        ods_pkg::OFS_STATUS: begin
          rd_val[ods_pkg::STAT_REF_BIT]   = ref_en_reg;
          rd_val[ods_pkg::STAT_LOCK_BIT]  = state_reg == ods_pkg::ST_LOCKED;
          rd_val[ods_pkg::STAT_FRAME_BIT] = state_reg == ods_pkg::ST_SHIFT;
          rd_val[ods_pkg::STAT_RSV_BIT]   = rsv_reg;
        end
        ods_pkg::OFS_LAST_WORD: rd_val = last_word_reg;
        ods_pkg::OFS_FEATURE:   rd_val = {28'h0000000, feature_reg};
        ods_pkg::OFS_COUNTS:    rd_val = {abort_cnt_reg, done_cnt_reg};
        default:                rd_hit = 1'b0;
      endcase
    end
  end

  // handshake and read data
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (PSEL && PENABLE && !pready_reg) begin
      pready_reg  <= 1'b1;
      prdata_reg  <= PWRITE ? 32'h0000_0000 : rd_val;
      pslverr_reg <= ~rd_hit;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // control register: bit 0 lets frames open
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= ods_pkg::CTRL_RST;
    end else if (apb_wr && PADDR == ods_pkg::OFS_CTRL) begin
      ctrl_reg <= {31'h00000000, PWDATA[ods_pkg::CTRL_EN_BIT]};
    end
  end

  assign PRDATA     = prdata_reg;
  assign PREADY     = pready_reg;
  assign PSLVERR    = pslverr_reg;
  assign REF_EN     = ref_en_reg;
  assign DAC_UPDATE = dac_update_reg;

  // ==================================================================
  // assertions
  // ==================================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  lock_hold_a: assert property (                         // [RQ10]
    state_reg == ods_pkg::ST_LOCKED && !frame_start |=> $stable(sr_reg))
    else $error("shift register moved while locked");
  word_count_a: assert property (                        // [RQ11]
    word_done |=> state_reg == ods_pkg::ST_LOCKED &&
                  last_word_reg == $past(w_in))
    else $error("word not taken at 32nd clock fall");
  // the rise itself clears the counter, so only later cycles must hold
  idle_hold_a: assert property (                         // [RQ20]
    pin_lvl[0] && !frame_end |=> $stable(bit_cnt_reg) && $stable(sr_reg))
    else $error("receiver moved with frame select high");
  abort_a: assert property (                             // [RQ13]
    frame_end && !frame_start && state_reg == ods_pkg::ST_SHIFT
    |=> state_reg == ods_pkg::ST_IDLE && bit_cnt_reg == 6'h00 &&
        $stable(input_reg) && $stable(dac_reg))
    else $error("aborted frame left state behind");
  start_a: assert property (                             // [RQ12]
    frame_start |=> state_reg == ods_pkg::ST_SHIFT)
    else $error("frame select fall did not open a frame");
  input_write_a: assert property (                       // [RQ16]
    word_ok && w_in.command_field == ods_pkg::CMD_WRITE_INPUT &&
    !w_in.channel_address_field[3]
    |=> input_reg[$past(ch)] == ($past(w_in.conversion_code) & MASK))
    else $error("input register not loaded");
  broadcast_a: assert property (                         // [RQ17]
    word_ok && w_in.command_field == ods_pkg::CMD_WRITE_INPUT &&
    w_in.channel_address_field == ods_pkg::ADDR_BROADCAST
    |=> input_reg == {8{$past(code)}})
    else $error("broadcast did not reach every channel");
  bad_addr_a: assert property (                          // [RQ17]
    word_ok && w_in.command_field == ods_pkg::CMD_WRITE_INPUT &&
    w_in.channel_address_field[3] &&
    w_in.channel_address_field != ods_pkg::ADDR_BROADCAST
    |=> $stable(input_reg))
    else $error("invalid address changed a channel");
  update_a: assert property (                            // [RQ18]
    word_ok && w_in.command_field == ods_pkg::CMD_UPDATE_DAC &&
    !w_in.channel_address_field[3]
    |=> DAC_UPDATE && dac_reg[$past(ch)] == $past(input_reg[ch]))
    else $error("output register not updated");
  code_mask_a: assert property (                         // [RQ6]
    ((input_reg[0] | input_reg[7]) & ~MASK) == 16'h0000)
    else $error("ignored low bits reached a channel");
  ref_cause_a: assert property (                         // [RQ15]
    $changed(ref_en_reg) |-> $past(word_ok))
    else $error("reference changed without a command");
  feature_a: assert property (                           // [RQ21]
    word_done |=> feature_reg == $past(w_in.feature_field))
    else $error("feature bits not kept");
  full_word_c: cover property (word_ok ##1 DAC_UPDATE);
  abort_c: cover property (
    frame_end && state_reg == ods_pkg::ST_SHIFT && bit_cnt_reg > 6'h10);
  apb_read_c: cover property (apb_done && !PWRITE && !PSLVERR);
  lock_clock_c: cover property (
    state_reg == ods_pkg::ST_LOCKED && pin_fall[1]);

endmodule : ods_frame_decoder

/* File: ods_host_model.sv */
`timescale 1ns/1ps
// ====================================================================
// host side of the three-wire link, 125 ns per serial bit
// ====================================================================
module ods_host_model (
  output logic sync_n,
  output logic sclk,
  output logic sdin
);
  // idle: frame closed, clock parked high, never free-running
  initial begin
    sync_n = 1'b1;
    sclk   = 1'b1;
    sdin   = 1'b0;
  end

  // one bit; data settles well ahead of the falling edge
  task automatic pulse(input logic b);
    sdin = b;
    #31.0 sclk = 1'b0;
    #62.5 sclk = 1'b1;
    #31.5 sdin = ~b;           // hold over: show the inverse
  endtask : pulse

  // top nb bits msb first, then extra clocks, optional close
  task automatic send(input logic [31:0] w, input int nb,
                      input int extra, input bit close);
    if (sync_n === 1'b0) begin
      sync_n = 1'b1;
      #100.0;
    end
    sync_n = 1'b0;
    #40.0;
    for (int i = 31; i > 31 - nb; i--)
      pulse(w[i]);
    for (int i = 0; i < extra; i++)
      pulse(~w[0]);
    #20.0 if (close) sync_n = 1'b1;
    #200.0;
  endtask : send

  // clock activity outside any frame
  task automatic stray(input int n);
    for (int i = 0; i < n; i++)
      pulse(1'b1);
  endtask : stray
endmodule : ods_host_model

/* File: octal_dac_serial_frame_decoder_tb.sv */
`timescale 1ns/1ps
// ====================================================================
// bench: apb master, host link model, scenario tasks
// ====================================================================
module octal_dac_serial_frame_decoder_tb;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ref_en;
  logic        dac_update;
  logic        sync_n;
  logic        sclk;
  logic        sdin;
  logic [31:0] rdat;
  logic        rerr;
  int          n_fail;
  int          check_count;
  int          n_upd;

  // ==================================================================
  // clock, design, host
  // ==================================================================
  initial clk = 1'b0;
  always #5 clk = ~clk;

  ods_frame_decoder #(.RES_BITS(16)) dut (
    .CLK(clk), .RST_N(rst_n), .SYNC_N(sync_n), .SCLK(sclk),
    .SDIN(sdin), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .REF_EN(ref_en),
    .DAC_UPDATE(dac_update)
  );
  ods_host_model host (.sync_n(sync_n), .sclk(sclk), .sdin(sdin));

  // count load pulses; a pulse lasts one cycle
  always @(posedge clk) if (dac_update === 1'b1) n_upd <= n_upd + 1;

  // ==================================================================
  // helpers
  // ==================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // one transfer; answer taken at the edge that sees pready
  // no cycle limit here: a hang is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, "read");
  endtask : rd

  function automatic logic [31:0] mk(input logic [3:0] c,
    input logic [3:0] a, input logic [15:0] v, input logic [3:0] f);
    return {4'h0, c, a, v, f};
  endfunction : mk

  // ==================================================================
  // scenarios
  // ==================================================================
  task automatic t_chans();
    logic [15:0] v;
    for (int ch = 0; ch < 8; ch++) begin
      v = (ch == 7) ? 16'hFFFF : 16'(16'h1357 * ch);
      host.send(mk(4'h0, 4'(ch), v, 4'hF), 32, 0, 1'b1);
      rd(8'h20 + 8'(4 * ch), {16'h0, v});
    end
    rd(ods_pkg::OFS_LAST_WORD, mk(4'h0, 4'h7, 16'hFFFF, 4'hF));
    rd(ods_pkg::OFS_FEATURE, 32'h0000_000F);
    chk(n_upd, 32'h0, "no load on input write");
    $display("t_chans done");
  endtask : t_chans

  task automatic t_bcast();
    host.send(mk(4'h0, 4'hF, 16'h4242, 4'h0), 32, 0, 1'b1);
    host.send(mk(4'h0, 4'h9, 16'h0BAD, 4'h0), 32, 0, 1'b1);
    for (int ch = 0; ch < 8; ch++)
      rd(8'h20 + 8'(4 * ch), 32'h0000_4242);
    $display("t_bcast done");
  endtask : t_bcast

  // update ch 3, held frame with extra clocks
  task automatic t_update();
    logic [31:0] w;
    w = mk(4'h1, 4'h3, 16'h0000, 4'h0);
    host.send(w, 32, 3, 1'b0);
    chk(n_upd, 32'h1, "load while frame low");
    rd(ods_pkg::OFS_LAST_WORD, w);
    rd(8'h4C, 32'h0000_4242);
    rd(8'h40, 32'h0000_0000);
    $display("t_update done");
  endtask : t_update

  task automatic t_abort();
    host.send(mk(4'h0, 4'h0, 16'h7777, 4'h0), 20, 0, 1'b1);
    host.stray(5);
    rd(8'h20, 32'h0000_4242);
    rd(ods_pkg::OFS_COUNTS, 32'h0001_000B);
    host.send(mk(4'h0, 4'h0, 16'h0101, 4'h0), 32, 0, 1'b1);
    rd(8'h20, 32'h0000_0101);
    $display("t_abort done");
  endtask : t_abort

  task automatic t_ref();
    host.send(mk(ods_pkg::CMD_REF_DEFAULT, 4'h0, 16'h0, 4'h1), 32, 0, 1);
    chk({31'h0, ref_en}, 32'h1, "ref on");
    apb(1'b0, ods_pkg::OFS_STATUS, 32'h0);
    chk(rdat & 32'h1, 32'h1, "status ref");
    host.send(mk(ods_pkg::CMD_REF_DEFAULT, 4'h0, 16'h0, 4'h0), 32, 0, 1);
    chk({31'h0, ref_en}, 32'h0, "ref off");
    $display("t_ref done");
  endtask : t_ref

  // first bit one, then a map miss
  task automatic t_bad();
    host.send(32'h8000_0000 | mk(4'h0, 4'h0, 16'h1234, 4'h0), 32, 0, 1);
    rd(8'h20, 32'h0000_0101);
    apb(1'b0, ods_pkg::OFS_STATUS, 32'h0);
    chk(rdat & 32'h8, 32'h8, "reserved seen");
    apb(1'b1, ods_pkg::OFS_STATUS, 32'h0000_0008);
    apb(1'b0, ods_pkg::OFS_STATUS, 32'h0);
    chk(rdat & 32'h8, 32'h0, "reserved clear");
    apb(1'b0, 8'h14, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1, "unmapped");
    // receiver disabled: a full frame must leave channel 0 alone
    apb(1'b1, ods_pkg::OFS_CTRL, 32'h0);
    rd(ods_pkg::OFS_CTRL, 32'h0);
    host.send(mk(4'h0, 4'h0, 16'h5555, 4'h0), 32, 0, 1);
    rd(8'h20, 32'h0000_0101);
    apb(1'b1, ods_pkg::OFS_CTRL, 32'h1);
    $display("t_bad done");
  endtask : t_bad

  // ==================================================================
  // end of run
  // ==================================================================
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // some 17 frames of about 4.3 us each
  initial begin
    #300us;
    n_fail++;
    $display("Error %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    n_fail  = 0;
    n_upd   = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, ref_en}, 32'h0, "ref at reset");
    rd(ods_pkg::OFS_CTRL, ods_pkg::CTRL_RST);
    t_chans();
    t_bcast();
    t_update();
    t_abort();
    t_ref();
    t_bad();
    conclude();
  end
endmodule : octal_dac_serial_frame_decoder_tb
